// ---- inc/ilc_defs.vh ----
`ifndef ILC_DEFS_VH
`define ILC_DEFS_VH

// Register byte offsets.
`define ILC_OFF_IRQ_EN 12'h000
`define ILC_OFF_IRQ_DIS 12'h004
`define ILC_OFF_IRQ_MASK 12'h008
`define ILC_OFF_IRQ_STAT 12'h00c
`define ILC_OFF_OD_EN 12'h010
`define ILC_OFF_OD_DIS 12'h014
`define ILC_OFF_OD_STAT 12'h018
`define ILC_OFF_PU_DIS 12'h020
`define ILC_OFF_PU_EN 12'h024
`define ILC_OFF_PU_STAT 12'h028
`define ILC_OFF_FA_SEL 12'h030
`define ILC_OFF_FB_SEL 12'h034
`define ILC_OFF_F_STAT 12'h038
`define ILC_OFF_OW_EN 12'h040
`define ILC_OFF_OW_DIS 12'h044
`define ILC_OFF_OW_STAT 12'h048
`define ILC_OFF_OUT_LVL 12'h050

// Reset values.
`define ILC_RST_IRQ_MASK 32'h00000000
`define ILC_RST_OD 32'h00000000
`define ILC_RST_PU_OFF 32'h00000000
`define ILC_RST_FUNC 32'h00000000
`define ILC_RST_OW 32'h00000000
`define ILC_RST_OUT_LVL 32'h00000000

// Input synchroniser depth.
`define ILC_SYNC_STAGES 3

`endif

// ---- rtl/ilc_line_sync.v ----
// Three-stage synchroniser with change detect; a change counts once stages two and three agree.
module ilc_line_sync #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Pins and result
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_r,
    output wire [WIDTH-1:0] change
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    reg primed_r;
    reg [1:0] fill_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
            level_r <= {WIDTH{1'b0}};
            primed_r <= 1'b0;
            fill_r <= 2'd0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (fill_r != 2'd3) begin
                fill_r <= fill_r + 2'd1;
            end
            // The reset zeros in the stages are not a pin level, so wait until they are flushed.
            if ((fill_r == 2'd3) && (s2_r == s3_r)) begin
                level_r <= s3_r;
                primed_r <= 1'b1;
            end
        end
    end

    // The first settled level after reset is not reported as a change.
    assign change = (primed_r && (s2_r == s3_r)) ? (s3_r ^ level_r) : {WIDTH{1'b0}};
endmodule // ilc_line_sync

// ---- rtl/ilc_set_clr.v ----
// One per-line state bit set by one register and cleared by its partner.
module ilc_set_clr #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Strobes
    input wire set_wr,
    input wire clr_wr,
    input wire [WIDTH-1:0] wdata,
    // State
    output reg [WIDTH-1:0] state_r
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= RESET_VAL;
        end else if (set_wr) begin
            state_r <= state_r | wdata;
        end else if (clr_wr) begin
            state_r <= state_r & ~wdata;
        end
    end
endmodule // ilc_set_clr

// ---- rtl/ilc_top.v ----
`include "ilc_defs.vh"

module ilc_top #(
    parameter LINES = 32
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Pins
    input wire [LINES-1:0] pin_in,
    output reg [LINES-1:0] pin_out,
    output reg [LINES-1:0] pin_oe,
    output reg [LINES-1:0] pullup_on,
    // Function routing and drive request from the controller core
    input wire [LINES-1:0] drive_req,
    output reg [LINES-1:0] func_second,
    // Interrupt
    output reg irq
);
    wire setup = psel && !penable;
    wire wr = setup && pwrite;
    wire rd = setup && !pwrite;

    wire [LINES-1:0] wd = pwdata[LINES-1:0];
    wire [LINES-1:0] irq_mask;
    wire [LINES-1:0] od_state;
    wire [LINES-1:0] pu_off;
    wire [LINES-1:0] f_state;
    wire [LINES-1:0] ow_state;
    wire [LINES-1:0] line_level;
    wire [LINES-1:0] line_change;
    reg [LINES-1:0] irq_stat_r;
    reg [LINES-1:0] out_lvl_r;
    reg [31:0] rd_nxt;
    reg hit_nxt;

    // Interrupt mask pair.
    ilc_set_clr #(.WIDTH(LINES), .RESET_VAL(`ILC_RST_IRQ_MASK)) u_mask (
        .pclk(pclk),
        .presetn(presetn),
        .set_wr(wr && (paddr == `ILC_OFF_IRQ_EN)),
        .clr_wr(wr && (paddr == `ILC_OFF_IRQ_DIS)),
        .wdata(wd),
        .state_r(irq_mask)
    );

    // Open-drain pair.
    ilc_set_clr #(.WIDTH(LINES), .RESET_VAL(`ILC_RST_OD)) u_od (
        .pclk(pclk),
        .presetn(presetn),
        .set_wr(wr && (paddr == `ILC_OFF_OD_EN)),
        .clr_wr(wr && (paddr == `ILC_OFF_OD_DIS)),
        .wdata(wd),
        .state_r(od_state)
    );

    // Pull-up pair; stored as "off" so the status reads the inverted sense directly.
    ilc_set_clr #(.WIDTH(LINES), .RESET_VAL(`ILC_RST_PU_OFF)) u_pu (
        .pclk(pclk),
        .presetn(presetn),
        .set_wr(wr && (paddr == `ILC_OFF_PU_DIS)),
        .clr_wr(wr && (paddr == `ILC_OFF_PU_EN)),
        .wdata(wd),
        .state_r(pu_off)
    );

    // Function select pair; 1 means second function.
    ilc_set_clr #(.WIDTH(LINES), .RESET_VAL(`ILC_RST_FUNC)) u_func (
        .pclk(pclk),
        .presetn(presetn),
        .set_wr(wr && (paddr == `ILC_OFF_FB_SEL)),
        .clr_wr(wr && (paddr == `ILC_OFF_FA_SEL)),
        .wdata(wd),
        .state_r(f_state)
    );

    // Output write gating pair.
    ilc_set_clr #(.WIDTH(LINES), .RESET_VAL(`ILC_RST_OW)) u_ow (
        .pclk(pclk),
        .presetn(presetn),
        .set_wr(wr && (paddr == `ILC_OFF_OW_EN)),
        .clr_wr(wr && (paddr == `ILC_OFF_OW_DIS)),
        .wdata(wd),
        .state_r(ow_state)
    );

    ilc_line_sync #(.WIDTH(LINES)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pin_in),
        .level_r(line_level),
        .change(line_change)
    );

    // Status: a change in the same cycle as the clearing read survives.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= {LINES{1'b0}};
        end else if (rd && (paddr == `ILC_OFF_IRQ_STAT)) begin
            irq_stat_r <= line_change;
        end else begin
            irq_stat_r <= irq_stat_r | line_change;
        end
    end

    // Direct output level writes only reach lines with writing enabled.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_lvl_r <= `ILC_RST_OUT_LVL;
        end else if (wr && (paddr == `ILC_OFF_OUT_LVL)) begin
            out_lvl_r <= (out_lvl_r & ~ow_state) | (wd & ow_state);
        end
    end

    // Read decode; write-only offsets read zero without error, unmapped offsets read zero with pslverr.
    always @* begin
        rd_nxt = 32'h00000000;
        hit_nxt = 1'b1;
        if (paddr == `ILC_OFF_IRQ_MASK) begin
            rd_nxt[LINES-1:0] = irq_mask;
        end else if (paddr == `ILC_OFF_IRQ_STAT) begin
            rd_nxt[LINES-1:0] = irq_stat_r;
        end else if (paddr == `ILC_OFF_OD_STAT) begin
            rd_nxt[LINES-1:0] = od_state;
        end else if (paddr == `ILC_OFF_PU_STAT) begin
            rd_nxt[LINES-1:0] = pu_off;
        end else if (paddr == `ILC_OFF_F_STAT) begin
            rd_nxt[LINES-1:0] = f_state;
        end else if (paddr == `ILC_OFF_OW_STAT) begin
            rd_nxt[LINES-1:0] = ow_state;
        end else if (paddr == `ILC_OFF_OUT_LVL) begin
            rd_nxt[LINES-1:0] = out_lvl_r;
        end else if ((paddr == `ILC_OFF_IRQ_EN) || (paddr == `ILC_OFF_IRQ_DIS) ||
                     (paddr == `ILC_OFF_OD_EN) || (paddr == `ILC_OFF_OD_DIS) ||
                     (paddr == `ILC_OFF_PU_EN) || (paddr == `ILC_OFF_PU_DIS) ||
                     (paddr == `ILC_OFF_FA_SEL) || (paddr == `ILC_OFF_FB_SEL) ||
                     (paddr == `ILC_OFF_OW_EN) || (paddr == `ILC_OFF_OW_DIS)) begin
            rd_nxt = 32'h00000000;
        end else begin
            hit_nxt = 1'b0;
        end
    end

    // No wait state: setup cycle, then pready in the first access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_nxt;
            pready <= 1'b1;
            pslverr <= !hit_nxt;
        end else begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Pin drivers are registered so every output comes from a flip-flop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= {LINES{1'b0}};
            pin_oe <= {LINES{1'b0}};
            pullup_on <= {LINES{1'b0}};
            func_second <= {LINES{1'b0}};
            irq <= 1'b0;
        end else begin
            pin_out <= out_lvl_r & ~od_state;
            pin_oe <= drive_req & (~od_state | ~out_lvl_r);
            pullup_on <= ~pu_off;
            func_second <= f_state;
            irq <= |(irq_stat_r & irq_mask);
        end
    end
endmodule // ilc_top

// ---- tb/ilc_pin_pad.sv ----
module ilc_pin_pad (
    // Device side
    input wire [31:0] pin_out,
    input wire [31:0] pin_oe,
    input wire [31:0] pullup_on,
    // Outside driver and resolved level
    input wire [31:0] ext_en,
    input wire [31:0] ext_val,
    output wire [31:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A floating line without pull-up shows the inverse of the output, never a lucky value.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & pullup_on) | (~pin_oe & ~ext_en & ~pullup_on & ~pin_out);
endmodule // ilc_pin_pad

// ---- tb/ilc_top_sva.sv ----
`include "ilc_defs.vh"
module ilc_top_sva (
    // Clock, reset and bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Pins and routing
    input wire [31:0] pin_out,
    input wire [31:0] pullup_on,
    input wire [31:0] func_second,
    input wire irq
);
    wire setup = psel && !penable;
    wire wr = setup && pwrite;
    wire [2:0] g = paddr[6:4];
    wire [1:0] k = paddr[3:2];
    wire mapped = paddr[11:7] == 5'h0 && paddr[1:0] == 2'h0
        && (g == 3'h0 || (g < 3'h5 && k != 2'h3) || (g == 3'h5 && k == 2'h0));
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (setup |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_data_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray prdata");
    a_err_unmapped: assert property (setup |=> pslverr == !$past(mapped))
        else $error("pslverr wrong");
    a_od_low: assert property (wr && paddr == `ILC_OFF_OD_EN |-> ##2
        (pin_out & $past(pwdata, 2)) == 32'h0) else $error("open drain high");
    a_pu_off: assert property (wr && paddr == `ILC_OFF_PU_DIS |-> ##2
        (pullup_on & $past(pwdata, 2)) == 32'h0) else $error("pull-up on");
    a_pu_on: assert property (wr && paddr == `ILC_OFF_PU_EN |-> ##2
        (~pullup_on & $past(pwdata, 2)) == 32'h0) else $error("pull-up off");
    a_func_b: assert property (wr && paddr == `ILC_OFF_FB_SEL |-> ##2
        (~func_second & $past(pwdata, 2)) == 32'h0) else $error("not second");
    a_func_a: assert property (wr && paddr == `ILC_OFF_FA_SEL |-> ##2
        (func_second & $past(pwdata, 2)) == 32'h0) else $error("not first");
    a_irq_masked: assert property (pready && !pwrite && paddr == `ILC_OFF_IRQ_MASK
        && prdata == 32'h0 |=> !irq) else $error("irq while masked");
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
    c_od: cover property (wr && paddr == `ILC_OFF_OD_EN);
endmodule // ilc_top_sva

bind ilc_top ilc_top_sva ilc_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pullup_on(pullup_on),
    .func_second(func_second), .irq(irq));

// ---- tb/ilc_top_tb.sv ----
`include "ilc_defs.vh"
module ilc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, drive_req = 32'h0, ext_en = 32'h0, ext_val = 32'h0, rd;
    logic [31:0] prdata, pin_out, pin_oe, pullup_on, func_second, pin_in;
    int n_fail = 0, tests_run = 0;
    ilc_top ilc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .drive_req(drive_req), .func_second(func_second), .irq(irq));
    ilc_pin_pad ilc_pin_pad_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    initial forever #12.5 pclk = ~pclk;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", s, e, g);
            n_fail++;
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, e, rd);
    endtask
    task automatic t_reset;
        rdchk(`ILC_OFF_IRQ_MASK, 32'h0, "mask");
        rdchk(`ILC_OFF_PU_STAT, 32'h0, "pull-up status");
        rdchk(`ILC_OFF_F_STAT, 32'h0, "function status");
        chk("pullup_on", 32'hffffffff, pullup_on);
    endtask
    task automatic t_pairs;
        logic [11:0] sa [5] = '{`ILC_OFF_IRQ_EN, `ILC_OFF_OD_EN, `ILC_OFF_PU_DIS,
            `ILC_OFF_FB_SEL, `ILC_OFF_OW_EN};
        logic [11:0] ca [5] = '{`ILC_OFF_IRQ_DIS, `ILC_OFF_OD_DIS, `ILC_OFF_PU_EN,
            `ILC_OFF_FA_SEL, `ILC_OFF_OW_DIS};
        logic [11:0] ra [5] = '{`ILC_OFF_IRQ_MASK, `ILC_OFF_OD_STAT, `ILC_OFF_PU_STAT,
            `ILC_OFF_F_STAT, `ILC_OFF_OW_STAT};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, sa[i], 32'h800000a5);
            apb(1'b1, sa[i], 32'h0);
            apb(1'b1, ra[i], 32'hffffffff);
            rdchk(ra[i], 32'h800000a5, "state set");
            apb(1'b1, ca[i], 32'h80000005);
            apb(1'b1, ca[i], 32'h0);
            rdchk(ra[i], 32'h000000a0, "state clear");
            if (i == 2) chk("pullup_on", 32'hffffff5f, pullup_on);
            if (i == 3) chk("func_second", 32'h000000a0, func_second);
            apb(1'b1, ca[i], 32'hffffffff);
        end
    endtask
    task automatic t_drive;
        drive_req <= 32'hffffffff;
        apb(1'b1, `ILC_OFF_OW_EN, 32'h000000ff);
        apb(1'b1, `ILC_OFF_OUT_LVL, 32'h00000f0f);
        rdchk(`ILC_OFF_OUT_LVL, 32'h0000000f, "output level");
        chk("pin_out", 32'h0000000f, pin_out);
        chk("pin_oe", 32'hffffffff, pin_oe);
        apb(1'b1, `ILC_OFF_OD_EN, 32'h00000003);
        rdchk(`ILC_OFF_OD_STAT, 32'h00000003, "open drain");
        chk("pin_out", 32'h0000000c, pin_out);
        chk("pin_oe", 32'hfffffffc, pin_oe);
        apb(1'b1, `ILC_OFF_OD_DIS, 32'hffffffff);
        drive_req <= 32'h0;
    endtask
    task automatic t_change;
        ext_en <= 32'h00000210;
        apb(1'b1, `ILC_OFF_IRQ_EN, 32'h00000010);
        repeat (8) @(posedge pclk);
        apb(1'b0, `ILC_OFF_IRQ_STAT, 32'h0);
        rdchk(`ILC_OFF_IRQ_STAT, 32'h0, "quiet status");
        ext_val <= 32'h00000210;
        repeat (8) @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk(`ILC_OFF_IRQ_STAT, 32'h00000210, "status");
        rdchk(`ILC_OFF_IRQ_STAT, 32'h0, "status after read");
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, `ILC_OFF_IRQ_DIS, 32'h00000010);
        ext_val <= 32'h0;
        repeat (8) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        rdchk(`ILC_OFF_IRQ_STAT, 32'h00000210, "masked status");
    endtask
    task automatic t_unmapped;
        apb(1'b0, 12'h01c, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("prdata", 32'h0, rd);
        apb(1'b1, 12'hffc, 32'h1);
        chk("pslverr", 32'h1, {31'h0, err});
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(25 * 4000);
        n_fail++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_pairs;
        t_drive;
        t_change;
        t_unmapped;
        test_done;
    end
endmodule // ilc_top_tb
